// ### verilog/tabs_defs.svh
/*
 * Offsets, control bits, reset values and timing counts of the
 * trigger arm burst sequencer.
 * Assumes a 100 MHz aclk and byte addresses on an 8-bit bus.
 */
`ifndef TABS_DEFS_SVH
`define TABS_DEFS_SVH

// register byte offsets
`define R_CTRL 8'h00
`define R_ARMCNT 8'h04
`define R_NRDG 8'h08
`define R_TIMER 8'h0c
`define R_SWPINT 8'h10
`define R_SWPCNT 8'h14
`define R_DELAY 8'h18
`define R_LEVEL 8'h1c
`define R_STATUS 8'h20
`define R_EXTNEED 8'h24
`define R_DATA 8'h28

// control word action bits
`define CTRL_GO 31
`define CTRL_PRESET 30

// clock and sampling times
`define CLK_HZ 100000000
`define CLK_NS 10
`define MIN_SAMPLE_NS 20000
`define PRESET_RATE_HZ 50000
`define PRESET_TIMER (`CLK_HZ / `PRESET_RATE_HZ)

// reset and preset values
`define RST_READINGS 16'h0001
`define RST_TIMER 32'h0000_0001
`define PRESET_READINGS 16'h0100
`define PRESET_RANGE_V 8'h0a
`define MEM_DEPTH 256
`define MEM_FULL 9'h100

`endif

// ### verilog/tabs_pkg.sv
/*
 * Types of the trigger arm burst sequencer.
 * Assumes tabs_defs.svh for the numeric constants.
 */
package tabs_pkg;

    // event sources for arm, trigger and reading pacing
    typedef enum logic [3:0] {
        EV_AUTO, EV_HOLD, EV_SINGLE, EV_LEVEL, EV_LINE,
        EV_GET, EV_EXT, EV_HOST, EV_TIMER
    } event_src_t;

    // measurement modes
    typedef enum logic [2:0] {
        MD_DCV, MD_DIRECT_SAMPLED_AC_MODE, MD_DIRECT_SAMPLED_DC_MODE, MD_SUBSAMPLED_AC_MODE, MD_SUBSAMPLED_DC_MODE
    } meas_mode_t;

    // sequencing configuration, bits 17:0 of the control word
    typedef struct packed {
        event_src_t arm;
        event_src_t trigger_event_select;
        event_src_t pace;
        meas_mode_t mode;
        logic sync_ext;
        logic slope_pos;
        logic ac_coupled;
    } seq_cfg_t;

    // front end settings driven to the analog side
    typedef struct packed {
        logic [15:0] level;
        logic [7:0] range_v;
        logic slope_pos;
        logic ac_coupled;
    } front_cfg_t;

endpackage

// ### verilog/trigger_arm_burst_sequencer.sv
/*
 * Arm, trigger and burst sequencer with sweep, subsample sync,
 * reading memory and an AXI4-Lite register slave.
 * Assumes events and readings synchronous to aclk.
 */
`timescale 1ns/1ps
`include "tabs_defs.svh"

module trigger_arm_burst_sequencer (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // measurement start events
    input wire logic level_event,
    input wire logic line_zero_cross,
    input wire logic bus_get_trigger,
    input wire logic ext_trigger,
    input wire logic host_read_req,
    // reading converter
    output logic take_reading,
    input wire logic reading_valid,
    input wire logic [31:0] reading_data,
    // live reading stream and front end settings
    output logic live_valid,
    output logic [31:0] live_data,
    output tabs_pkg::front_cfg_t front_cfg
);

    typedef enum logic [2:0] {
        S_IDLE, S_ARM, S_TRIGGER_EVENT_SELECT, S_BURST, S_SYNC, S_DELAY
    } seq_state_t;

    tabs_pkg::seq_cfg_t cfg_ff;
    seq_state_t state_ff;
    logic [15:0] arm_cnt_ff;
    logic [15:0] arm_left_ff;
    logic [15:0] nrdg_ff;
    logic [15:0] pre_ff;
    logic [15:0] swp_cnt_ff;
    logic [15:0] rd_left_ff;
    logic [15:0] post;
    logic [31:0] timer_ff;
    logic [31:0] swp_int_ff;
    logic [31:0] delay_ff;
    logic [31:0] dly_ff;
    logic [31:0] taken_ff;
    logic [31:0] ext_need_ff;
    logic [31:0] tick_cnt_ff;
    logic [23:0] level_ff;
    logic [47:0] prod;
    logic arm_en_ff;
    logic take_ff;
    logic tick;
    logic arm_hit;
    logic trigger_event_select_hit;
    logic pace_hit;
    logic sync_hit;
    logic subsamp;
    logic fin;
    logic [5:0] ev;
    // bus side
    logic aw_ff;
    logic w_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic wr_en;
    logic [31:0] wv;
    logic go_wr;
    logic preset_wr;
    logic pop;
    // reading memory
    logic [31:0] mem [`MEM_DEPTH];
    logic [7:0] wr_ptr_ff;
    logic [7:0] rd_ptr_ff;
    logic [8:0] used_ff;
    logic full;
    logic live_valid_ff;
    logic [31:0] live_data_ff;

    ////////////////////////////////////////////////////////////////
    // helpers

    // event select against the present events
    function automatic logic hit(tabs_pkg::event_src_t s, logic [5:0] e);
        case (s)
            tabs_pkg::EV_AUTO: hit = 1'b1;
            tabs_pkg::EV_SINGLE: hit = 1'b1;
            tabs_pkg::EV_LEVEL: hit = e[0];
            tabs_pkg::EV_LINE: hit = e[1];
            tabs_pkg::EV_GET: hit = e[2];
            tabs_pkg::EV_EXT: hit = e[3];
            tabs_pkg::EV_HOST: hit = e[4];
            tabs_pkg::EV_TIMER: hit = e[5];
            default: hit = 1'b0;
        endcase
    endfunction

    // byte lane merge
    function automatic logic [31:0] wm(logic [31:0] o, logic [31:0] n, logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // register read-back by address
    function automatic logic [31:0] reg_val(logic [7:0] a);
        case ({a[7:2], 2'b00})
            `R_CTRL: reg_val = {14'h0, cfg_ff};
            `R_ARMCNT: reg_val = {16'h0, arm_cnt_ff};
            `R_NRDG: reg_val = {pre_ff, nrdg_ff};
            `R_TIMER: reg_val = timer_ff;
            `R_SWPINT: reg_val = swp_int_ff;
            `R_SWPCNT: reg_val = {16'h0, swp_cnt_ff};
            `R_DELAY: reg_val = delay_ff;
            `R_LEVEL: reg_val = {8'h0, level_ff};
            `R_STATUS: reg_val = {arm_en_ff, 4'h0, 3'(state_ff), arm_left_ff[7:0], 7'h0, used_ff};
            `R_EXTNEED: reg_val = ext_need_ff;
            `R_DATA: reg_val = mem[rd_ptr_ff];
            default: reg_val = 32'h0000_0000;
        endcase
    endfunction

    // mapped offsets
    function automatic logic mapped(logic [7:0] a);
        mapped = ({a[7:2], 2'b00} <= `R_DATA);
    endfunction

    ////////////////////////////////////////////////////////////////
    // axi4-lite slave

    // handshakes and decoded write strobes
    assign awready = !aw_ff && !bvalid_ff;
    assign wready = !w_ff && !bvalid_ff;
    assign arready = !rvalid_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign wr_en = aw_ff && w_ff;
    assign wv = wm(reg_val(awaddr_ff), wdata_ff, wstrb_ff);
    assign go_wr = wr_en && ({awaddr_ff[7:2], 2'b00} == `R_CTRL) && wv[`CTRL_GO];
    assign preset_wr = wr_en && ({awaddr_ff[7:2], 2'b00} == `R_CTRL) && wv[`CTRL_PRESET];
    assign pop = arvalid && arready && ({araddr[7:2], 2'b00} == `R_DATA) && (used_ff != 9'h000);

    // write channel: address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'b00;
        end else begin
            if (awvalid && awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= awaddr;
            end
            if (wvalid && wready) begin
                w_ff <= 1'b1;
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
            if (wr_en) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= mapped(awaddr_ff) ? 2'b00 : 2'b10;
            end else if (bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read channel, answer one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= 2'b00;
        end else if (arvalid && arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= reg_val(araddr);
            rresp_ff <= mapped(araddr) ? 2'b00 : 2'b10;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // configuration registers

    // settings, preset and sweep
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_ff <= '{tabs_pkg::EV_AUTO, tabs_pkg::EV_AUTO, tabs_pkg::EV_AUTO,
                        tabs_pkg::MD_DCV, 1'b0, 1'b1, 1'b0};
            arm_cnt_ff <= 16'h0000;
            nrdg_ff <= `RST_READINGS;
            pre_ff <= 16'h0000;
            timer_ff <= `RST_TIMER;
            swp_int_ff <= 32'h0000_0000;
            swp_cnt_ff <= 16'h0000;
            delay_ff <= 32'h0000_0000;
            level_ff <= {16'h0000, `PRESET_RANGE_V};
        end else if (preset_wr) begin
            // fastest digitize setup
            cfg_ff <= '{tabs_pkg::EV_AUTO, tabs_pkg::EV_LEVEL, tabs_pkg::EV_TIMER,
                        tabs_pkg::MD_DCV, 1'b0, 1'b1, 1'b1};
            nrdg_ff <= `PRESET_READINGS;
            pre_ff <= 16'h0000;
            timer_ff <= 32'(`PRESET_TIMER);
            level_ff <= {16'h0000, `PRESET_RANGE_V};
        end else if (wr_en) begin
            case ({awaddr_ff[7:2], 2'b00})
                `R_CTRL: cfg_ff <= tabs_pkg::seq_cfg_t'(wv[17:0]);
                `R_ARMCNT: arm_cnt_ff <= wv[15:0];
                `R_NRDG: begin
                    nrdg_ff <= wv[15:0];
                    pre_ff <= wv[31:16];
                end
                `R_TIMER: timer_ff <= (wv == 32'h0000_0000) ? `RST_TIMER : wv;
                `R_SWPINT: swp_int_ff <= wv;
                `R_SWPCNT: begin
                    // count and interval set together
                    swp_cnt_ff <= wv[15:0];
                    nrdg_ff <= wv[15:0];
                    pre_ff <= 16'h0000;
                    timer_ff <= (swp_int_ff < 32'(`CLK_NS)) ? `RST_TIMER : swp_int_ff / 32'(`CLK_NS);
                end
                `R_DELAY: delay_ff <= wv;
                `R_LEVEL: level_ff <= wv[23:0];
                default: ;
            endcase
        end
    end

    // external triggers needed for a subsampled sweep
    assign prod = swp_cnt_ff * swp_int_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_need_ff <= 32'h0000_0000;
        end else begin
            ext_need_ff <= 32'((prod + 48'(`MIN_SAMPLE_NS - 1)) / 48'(`MIN_SAMPLE_NS));
        end
    end

    ////////////////////////////////////////////////////////////////
    // events and pacing timer

    // event qualification per stage
    assign ev = {tick, host_read_req, ext_trigger, bus_get_trigger, line_zero_cross, level_event};
    assign arm_hit = hit(cfg_ff.arm, ev);
    assign trigger_event_select_hit = hit(cfg_ff.trigger_event_select, ev);
    assign pace_hit = hit(cfg_ff.pace, ev);
    assign sync_hit = cfg_ff.sync_ext ? ext_trigger : level_event;
    assign subsamp = (cfg_ff.mode == tabs_pkg::MD_SUBSAMPLED_AC_MODE) || (cfg_ff.mode == tabs_pkg::MD_SUBSAMPLED_DC_MODE);
    assign post = (nrdg_ff > pre_ff) ? nrdg_ff - pre_ff : 16'h0000;
    assign tick = (tick_cnt_ff >= timer_ff - 32'h1);
    assign fin = ((state_ff == S_BURST) && (rd_left_ff == 16'h0000)) ||
                 ((state_ff == S_DELAY) && (dly_ff == 32'h0) && (taken_ff + 32'h1 >= ext_need_ff));

    // interval timer, restarted at the trigger
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_ff <= 32'h0000_0000;
        end else if (tick || ((state_ff == S_TRIGGER_EVENT_SELECT) && trigger_event_select_hit)) begin
            tick_cnt_ff <= 32'h0000_0000;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // sequencer

    // arm, trigger, burst and subsample flow
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= S_IDLE;
            arm_en_ff <= 1'b1;
            arm_left_ff <= 16'h0000;
            rd_left_ff <= 16'h0000;
            taken_ff <= 32'h0000_0000;
            dly_ff <= 32'h0000_0000;
            take_ff <= 1'b0;
        end else begin
            take_ff <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    if (arm_en_ff && (cfg_ff.arm != tabs_pkg::EV_HOLD)) begin
                        state_ff <= S_ARM;
                    end
                end
                S_ARM: begin
                    if (arm_hit) begin
                        taken_ff <= 32'h0000_0000;
                        state_ff <= subsamp ? S_SYNC : S_TRIGGER_EVENT_SELECT;
                    end
                end
                S_TRIGGER_EVENT_SELECT: begin
                    if (trigger_event_select_hit) begin
                        take_ff <= (post != 16'h0000);
                        rd_left_ff <= (post == 16'h0000) ? 16'h0000 : post - 16'h1;
                        state_ff <= S_BURST;
                    end else if ((pre_ff != 16'h0000) && pace_hit) begin
                        take_ff <= 1'b1; // pre-trigger readings
                    end
                end
                S_BURST: begin
                    if ((rd_left_ff != 16'h0000) && pace_hit) begin
                        take_ff <= 1'b1;
                        rd_left_ff <= rd_left_ff - 16'h1;
                    end
                end
                S_SYNC: begin
                    if (sync_hit) begin
                        dly_ff <= delay_ff;
                        state_ff <= S_DELAY;
                    end
                end
                S_DELAY: begin
                    if (dly_ff != 32'h0) begin
                        dly_ff <= dly_ff - 32'h1;
                    end else begin
                        take_ff <= 1'b1;
                        taken_ff <= taken_ff + 32'h1;
                        state_ff <= S_SYNC;
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
            if (fin) begin
                state_ff <= S_IDLE;
                if (cfg_ff.arm == tabs_pkg::EV_SINGLE) begin
                    arm_left_ff <= arm_left_ff - 16'h1;
                    if (arm_left_ff <= 16'h1) begin
                        arm_en_ff <= 1'b0;
                    end
                end
            end
            if (go_wr) begin
                arm_en_ff <= 1'b1;
                arm_left_ff <= (arm_cnt_ff == 16'h0) ? 16'h1 : arm_cnt_ff;
                state_ff <= S_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // reading memory and live stream

    assign full = (used_ff == `MEM_FULL);

    // circular store, oldest overwritten when full
    always_ff @(posedge aclk) begin
        if (reading_valid) begin
            mem[wr_ptr_ff] <= reading_data;
        end
    end

    // pointers keep time order for read-out
    always_ff @(posedge aclk) begin
        if (!aresetn || go_wr) begin
            wr_ptr_ff <= 8'h00;
            rd_ptr_ff <= 8'h00;
            used_ff <= 9'h000;
        end else begin
            if (reading_valid) begin
                wr_ptr_ff <= wr_ptr_ff + 8'h1;
            end
            if (pop || (reading_valid && full)) begin
                rd_ptr_ff <= rd_ptr_ff + 8'h1;
            end
            if (reading_valid && !full && !pop) begin
                used_ff <= used_ff + 9'h1;
            end else if (pop && !reading_valid) begin
                used_ff <= used_ff - 9'h1;
            end
        end
    end

    // live copy of each reading
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            live_valid_ff <= 1'b0;
            live_data_ff <= 32'h0000_0000;
        end else begin
            live_valid_ff <= reading_valid;
            live_data_ff <= reading_data;
        end
    end

    // outputs
    assign take_reading = take_ff;
    assign live_valid = live_valid_ff;
    assign live_data = live_data_ff;
    assign front_cfg = {level_ff[23:8], level_ff[7:0], cfg_ff.slope_pos, cfg_ff.ac_coupled};

    ////////////////////////////////////////////////////////////////
    // checks

    logic [31:0] gap_ff;

    // cycles since the last reading request
    always_ff @(posedge aclk) begin
        if (!aresetn || take_ff) begin
            gap_ff <= 32'h1;
        end else begin
            gap_ff <= gap_ff + 32'h1;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_hold_idle: assert property (
        (state_ff == S_IDLE) && (cfg_ff.arm == tabs_pkg::EV_HOLD) |=> (state_ff == S_IDLE))
        else $error("left idle under hold arming");
    chk_trigger_event_select_after_arm: assert property (
        $rose(state_ff == S_TRIGGER_EVENT_SELECT) |-> $past(state_ff) == S_ARM)
        else $error("trigger stage entered without arming");
    chk_arm_blocks_trigger_event_select: assert property (
        (state_ff == S_ARM) && !arm_hit && !go_wr |=> (state_ff == S_ARM) && !take_ff)
        else $error("trigger looked at before arming");
    chk_single_stop: assert property (
        fin && (cfg_ff.arm == tabs_pkg::EV_SINGLE) && (arm_left_ff == 16'h1) && !go_wr
        |=> !arm_en_ff ##1 (state_ff == S_IDLE))
        else $error("counted arming did not stop");
    chk_timer_pace: assert property (
        take_ff && ($past(state_ff) == S_BURST) && (cfg_ff.pace == tabs_pkg::EV_TIMER) && $stable(timer_ff)
        |-> gap_ff == timer_ff)
        else $error("timer paced readings misspaced");
    chk_ext_count: assert property (
        fin && (state_ff == S_DELAY) && !go_wr |=> (state_ff == S_IDLE) && take_ff)
        else $error("subsample sweep did not end on its count");
    chk_preset_vals: assert property (
        preset_wr |=> (nrdg_ff == `PRESET_READINGS) && (timer_ff == 32'(`PRESET_TIMER))
                      && (cfg_ff.trigger_event_select == tabs_pkg::EV_LEVEL) && cfg_ff.ac_coupled)
        else $error("preset values wrong");
    chk_sub_ignores: assert property (
        (state_ff == S_ARM) && arm_hit && subsamp && !go_wr |=> (state_ff == S_SYNC))
        else $error("subsampled mode used trigger stage");
    chk_bresp_hold: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data changed while waiting");

    cov_burst: cover property ((state_ff == S_TRIGGER_EVENT_SELECT) && trigger_event_select_hit ##1 (state_ff == S_BURST) ##[1:20] fin);
    cov_single_done: cover property (fin && (cfg_ff.arm == tabs_pkg::EV_SINGLE) && (arm_left_ff == 16'h1));
    cov_subsample: cover property ((state_ff == S_DELAY) ##1 (state_ff == S_SYNC));
    cov_overwrite: cover property (reading_valid && full);

endmodule

// ### sim/conv_model.sv
/* reading converter model: answers each take_reading pulse with
   one reading lat+1 cycles after the edge that samples it. assumes one request at a time. */
`timescale 1ns/1ps
module conv_model (
    // clock
    input wire logic aclk,
    // request, latency and answer
    input wire logic take_reading,
    input wire logic [3:0] lat,
    output logic reading_valid,
    output logic [31:0] reading_data
);
    int cnt = -1;

    ////////////////////////////////////////
    // data toggles while not valid so a stale word never matches
    initial begin
        reading_valid = 1'b0;
        reading_data = 32'h0000_0000;
    end
    always @(posedge aclk) begin
        reading_valid <= 1'b0;
        reading_data <= ~reading_data;
        if (cnt > 0) cnt <= cnt - 1;
        if (cnt == 0) begin
            reading_valid <= 1'b1;
            reading_data <= $urandom;
            cnt <= -1;
        end
        if (take_reading) cnt <= int'(lat);
    end
endmodule

// ### sim/trigger_arm_burst_sequencer_tb_top.sv
/* bench top: axi4-lite master, events, reading queues.
   assumes conv_model answers take_reading within two cycles. */
`timescale 1ns/1ps
`include "tabs_defs.svh"
module trigger_arm_burst_sequencer_tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [4:0] evs = 5'h00; // host, external, bus trigger, line, level
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, d;
    logic [1:0] r;
    logic [3:0] lat = 4'h0;
    wire awready, wready, bvalid, arready, rvalid, take_reading, reading_valid, live_valid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, reading_data, live_data;
    wire [25:0] front_cfg;
    int bad_count = 0, n_compared = 0, cyc = 0, takes = 0, last = 0, gap = 0;
    logic [31:0] lq[$], mq[$];

    trigger_arm_burst_sequencer trigger_arm_burst_sequencer_i (.aclk, .aresetn, .awvalid, .awready,
        .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
        .level_event(evs[0]), .line_zero_cross(evs[1]), .bus_get_trigger(evs[2]), .ext_trigger(evs[3]),
        .host_read_req(evs[4]), .take_reading, .reading_valid, .reading_data, .live_valid,
        .live_data, .front_cfg);
    conv_model conv_model_i (.aclk, .take_reading, .lat, .reading_valid, .reading_data);

    //////////////////////////////////////////
    // clock and cycle limit
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // bus write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        lat <= 4'($urandom_range(1, 0));
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'($urandom);
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && !bready) bready <= 1'b1;
        end while (!(bvalid && bready));
        r = bresp;
        bready <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'($urandom);
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && !rready) rready <= 1'b1;
        end while (!(rvalid && rready));
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        #1;
    endtask

    // one-cycle pulse on an event input, then three idle cycles
    task automatic pulse(input int k);
        @(posedge aclk);
        evs[k] <= 1'b1;
        @(posedge aclk);
        evs[k] <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    // model: pulse count, spacing, live and stored reading order
    always @(negedge aclk) begin
        if (take_reading === 1'b1) begin
            takes++;
            gap = cyc - last;
            last = cyc;
        end
        if (live_valid === 1'b1) check(live_data, lq.pop_front());
        if (reading_valid === 1'b1) begin
            lq.push_back(reading_data);
            mq.push_back(reading_data);
        end
    end

    initial begin
        void'($urandom(32'h58d1_4d0f));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (20) @(posedge aclk);
        check(takes > 0, 1);
        wr(`R_CTRL, 32'h8000_4002);
        takes = 0;
        repeat (30) @(posedge aclk);
        check(takes, 0);
        wr(`R_TIMER, 32'h0000_0003);
        wr(`R_NRDG, 32'h0000_0003);
        wr(`R_CTRL, 32'h8000_1a02);
        takes = 0;
        repeat (20) @(posedge aclk);
        check(takes, 0);
        pulse(3);
        repeat (17) @(posedge aclk);
        check(takes, 3);
        check(gap, 3);
        // arm on bus trigger, trigger on line crossing, pace on host request, direct mode
        wr(`R_NRDG, 32'h0000_0002);
        wr(`R_CTRL, 32'h8001_51c2 | (32'($urandom_range(2, 1)) << 3));
        takes = 0;
        pulse(1);
        check(takes, 0);
        pulse(2);
        pulse(1);
        check(takes, 1);
        pulse(4);
        check(takes, 2);
        wr(`R_ARMCNT, 32'h0000_0004);
        wr(`R_NRDG, 32'h0000_0001);
        wr(`R_CTRL, 32'h8000_8002);
        takes = 0;
        mq.delete();
        repeat (60) @(posedge aclk);
        check(takes, 4);
        rd(`R_STATUS);
        check(d[31], 0);
        for (int i = 0; i < 4; i++) begin
            rd(`R_DATA);
            check(d, mq.pop_front());
        end
        wr(`R_SWPINT, 32'h0000_0064);
        wr(`R_SWPCNT, 32'h0000_1000);
        rd(`R_EXTNEED);
        check(d, (4096 * 100 + `MIN_SAMPLE_NS - 1) / `MIN_SAMPLE_NS);
        rd(`R_TIMER);
        check(d, 100 / `CLK_NS);
        wr(`R_CTRL, 32'h4000_0000);
        rd(`R_NRDG);
        check(d[15:0], `PRESET_READINGS);
        rd(`R_TIMER);
        check(d, `PRESET_TIMER);
        check(front_cfg, {16'h0000, `PRESET_RANGE_V, 2'b11});
        // subsampled sweep of three readings, external sync, delay 4, one arming
        wr(`R_SWPINT, 32'h0000_4e20);
        wr(`R_SWPCNT, 32'h0000_0003);
        wr(`R_DELAY, 32'h0000_0004);
        wr(`R_ARMCNT, 32'h0000_0001);
        wr(`R_CTRL, 32'h8000_8006 | (32'($urandom_range(4, 3)) << 3));
        takes = 0;
        repeat (10) @(posedge aclk);
        check(takes, 0);
        pulse(0);
        repeat (4) @(posedge aclk);
        check(takes, 0);
        for (int i = 1; i <= 4; i++) begin
            pulse(3);
            check(takes, i - 1);
            repeat (4) @(posedge aclk);
            check(takes, (i > 3) ? 3 : i);
        end
        wr(8'h40, 32'h0000_0000);
        check(r, 2'b10);
        rd(8'h40);
        check(r, 2'b10);
        report_and_stop();
    end
endmodule
